// ==== iad_axi_master.sv ====
/*
  AXI4-Lite master model standing in for the host of the add datapath.
  Assumes one clock aclk; the bench calls wr and rd, never both at once.
*/
`timescale 1ns/1ps
`default_nettype none

module iad_axi_master (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic [2:0]       awprot,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic [2:0]       arprot,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
  end

  // ready and valid are sampled at the rising edge that takes the item,
  // and the request is released by non-blocking assignment on that edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // read data are taken at the edge where rvalid is seen with rready high
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ==== iad_core.sv ====
/*
  Integer add datapath with its own register file, reached over AXI4-Lite.
  Writing the instruction register runs one add; reads stall while it runs.
  Assumes a single AXI4-Lite master on aclk and synchronous active-low reset.
*/
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
// Operation
// RULE_01: plain sum writes target, carry ignored
// RULE_02: carrying sum writes target, updates carry
// RULE_03: carry set when unsigned sum overflows
// RULE_04: extended sum adds carry flag as input
// RULE_05: record bit updates condition field zero
// RULE_06: overflow enable updates wrap and sticky
// RULE_07: decode carrying sum, opcode 31/10
// RULE_08: decode extended sum, opcode 31/138
// RULE_09: immediate with zero source loads constant
// RULE_10: immediate sum adds register, no flags
// RULE_11: next address is current plus four
// RULE_12: sign extension replicates top bit
// RULE_13: overflow sets wrap flag, ORs sticky
// RULE_14: condition from signed compare, copy sticky
`timescale 1ns/1ps
`default_nettype none

module iad_core
  import iad_pkg::*;
#(
  parameter logic [5:0] OPC_ADDI = 6'h0e,  // primary code of the immediate sum
  parameter logic [8:0] XO_ADD   = 9'h10a  // extended code of the plain sum
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  ////////////////////////////////////////////////////////////////////////
  // state
  iad_state_t  st, next_st;             // sequencer
  logic [31:0] instr, next_instr;       // instruction being run
  logic [31:0] current_instr_addr, next_cia;           // current instruction address
  logic [31:0] next_instr_addr, next_nia;           // next instruction address
  logic [31:0] fixed_point_exception_reg, next_xer;           // fixed point exception register
  logic [3:0]  cr0, next_cr0;           // condition field zero
  logic        bad, next_bad;           // last word was not an add
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // register file ports
  logic        mem_we;
  logic [4:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic [4:0]  mem_raddr_a;
  logic [31:0] rdata_a, rdata_b;

  // instruction fields
  logic [4:0]  target_reg_field, source_a_field, source_b_field;
  logic        ovf_enable_bit, record_bit;
  logic [15:0] constant_operand_field;

  // datapath
  iad_op_t     op;                      // decoded operation
  logic [31:0] a_in, b_in;              // adder operands
  logic        c_in;                    // adder carry in
  logic [32:0] sum;                     // result with carry out
  logic        sov;                     // signed wrap of this sum
  logic        wr_go, rd_go;            // bus requests taken this cycle
  logic        reg_form;                // op has oe and record bits

  ////////////////////////////////////////////////////////////////////////
  // functions

  // classify the instruction word
  function automatic iad_op_t decode_op(input logic [31:0] w);
    logic [5:0] opc;
    logic [8:0] xo;
    opc = w[OPC_LSB +: 6];
    xo  = w[XO_LSB +: 9];
    if (opc == OPC_X && xo == XO_ADD) begin
      decode_op = OP_ADD;
    end else if (opc == OPC_X && xo == XO_ADDC) begin  // see RULE_07
      decode_op = OP_ADDC;
    end else if (opc == OPC_X && xo == XO_ADDE) begin  // see RULE_08
      decode_op = OP_ADDE;
    end else if (opc == OPC_ADDI) begin
      decode_op = OP_ADDI;
    end else begin
      decode_op = OP_BAD;
    end
  endfunction

  // widen a 16-bit constant by copying its top bit
  function automatic logic [31:0] sign_extend(input logic [15:0] v);
    sign_extend = {{16{v[15]}}, v};  // see RULE_12
  endfunction

  // signed wrap: like-signed operands giving an unlike-signed result
  function automatic logic wrap_signed(input logic [31:0] a, input logic [31:0] b,
                                       input logic [31:0] r);
    wrap_signed = (a[31] == b[31]) && (r[31] != a[31]);
  endfunction

  // replace the bytes selected by the strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    apply_strb = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        apply_strb[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // field extraction and register file
  assign target_reg_field       = instr[RT_LSB +: 5];
  assign source_a_field         = instr[RA_LSB +: 5];
  assign source_b_field         = instr[RB_LSB +: 5];
  assign ovf_enable_bit         = instr[OE_BIT];
  assign record_bit             = instr[RC_BIT];
  assign constant_operand_field = instr[15:0];
  assign op                     = decode_op(instr);
  assign reg_form               = (op == OP_ADD) || (op == OP_ADDC) || (op == OP_ADDE);

  // port a serves the first source while fetching, the bus otherwise
  assign mem_raddr_a = (st == ST_FETCH) ? source_a_field : araddr[6:2];

  iad_gpr_mem #(
    .WIDTH (32),
    .DEPTH (32),
    .AW    (5)
  ) u_gpr (
    .aclk    (aclk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr_a (mem_raddr_a),
    .rdata_a (rdata_a),
    .raddr_b (source_b_field),
    .rdata_b (rdata_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes: one access at a time, only while idle, writes first
  assign wr_go    = (st == ST_IDLE) && awvalid && wvalid && !bvalid;
  assign rd_go    = (st == ST_IDLE) && arvalid && !rvalid && !wr_go;
  assign awready  = wr_go;
  assign wready   = wr_go;
  assign arready  = rd_go;

  ////////////////////////////////////////////////////////////////////////
  // one shared adder; operand choice depends on the operation
  always_comb begin
    a_in = rdata_a;
    b_in = rdata_b;
    c_in = 1'b0;
    case (op)
      OP_ADDE: begin
        c_in = fixed_point_exception_reg[XER_CA];  // see RULE_04
      end
      OP_ADDI: begin
        // zero source field means constant zero, not register zero
        a_in = (source_a_field == 5'h00) ? 32'h00000000 : rdata_a;  // see RULE_09
        b_in = sign_extend(constant_operand_field);                  // see RULE_10
      end
      default: begin
        c_in = 1'b0;  // plain and carrying sums take no carry in
      end
    endcase
    sum = {1'b0, a_in} + {1'b0, b_in} + {32'h00000000, c_in};  // see RULE_01
    sov = wrap_signed(a_in, b_in, sum[31:0]);
  end

  ////////////////////////////////////////////////////////////////////////
  // next values of sequencer, registers and bus answers
  always_comb begin
    next_st     = st;
    next_instr  = instr;
    next_cia    = current_instr_addr;
    next_nia    = next_instr_addr;
    next_xer    = fixed_point_exception_reg;
    next_cr0    = cr0;
    next_bad    = bad;
    next_bvalid = bvalid & ~bready;
    next_bresp  = bresp;
    next_rvalid = rvalid & ~rready;
    next_rresp  = rresp;
    next_rdata  = rdata;
    mem_we      = 1'b0;
    mem_waddr   = awaddr[6:2];
    mem_wdata   = wdata;
    case (st)
      ST_IDLE: begin
        if (wr_go) begin
          next_bvalid = 1'b1;
          next_bresp  = RESP_OKAY;
          if (awaddr[GPR_SEL] && awaddr[1:0] == 2'h0) begin
            // registers take whole words only; a partial write is refused
            if (wstrb == 4'hf) begin
              mem_we = 1'b1;
            end else begin
              next_bresp = RESP_SLVERR;
            end
          end else begin
            case (awaddr)
              OFS_INSTR: begin
                next_instr = apply_strb(instr, wdata, wstrb);
                next_st    = ST_FETCH;
              end
              OFS_CIA:  next_cia = apply_strb(current_instr_addr, wdata, wstrb);
              OFS_XER:  next_xer = apply_strb(fixed_point_exception_reg, wdata, wstrb) & XER_MASK;
              OFS_CR0: begin
                if (wstrb[0]) begin
                  next_cr0 = wdata[3:0];
                end
              end
              OFS_NIA, OFS_STAT: begin
                next_bresp = RESP_OKAY;  // read only, write ignored
              end
              default: next_bresp = RESP_SLVERR;
            endcase
          end
        end else if (rd_go) begin
          if (araddr[GPR_SEL] && araddr[1:0] == 2'h0) begin
            next_st = ST_RDG;  // array data arrive one cycle later
          end else begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (araddr)
              OFS_INSTR: next_rdata = instr;
              OFS_CIA:   next_rdata = current_instr_addr;
              OFS_NIA:   next_rdata = next_instr_addr;
              OFS_XER:   next_rdata = fixed_point_exception_reg;
              OFS_CR0:   next_rdata = {28'h0000000, cr0};
              OFS_STAT:  next_rdata = {31'h00000000, bad};
              default: begin
                next_rdata = 32'h00000000;
                next_rresp = RESP_SLVERR;
              end
            endcase
          end
        end
      end
      ST_FETCH: begin
        next_st = ST_EXEC;  // operands are being read from the array
      end
      ST_EXEC: begin
        next_st = ST_IDLE;
        if (op == OP_BAD) begin
          next_bad = 1'b1;  // nothing written, address not advanced
        end else begin
          next_bad  = 1'b0;
          mem_we    = 1'b1;
          mem_waddr = target_reg_field;
          mem_wdata = sum[31:0];              // see RULE_01
          next_nia  = current_instr_addr + NIA_STEP;         // see RULE_11
          next_cia  = current_instr_addr + NIA_STEP;
          if (op == OP_ADDC || op == OP_ADDE) begin
            next_xer[XER_CA] = sum[32];       // see RULE_02, RULE_03
          end
          if (reg_form && ovf_enable_bit) begin
            next_xer[XER_OV] = sov;                // see RULE_06
            next_xer[XER_SO] = fixed_point_exception_reg[XER_SO] | sov;  // see RULE_13
          end
          if (reg_form && record_bit) begin
            next_cr0[CR_LT] = sum[31];                                // see RULE_05
            next_cr0[CR_GT] = !sum[31] && (sum[31:0] != 32'h00000000); // see RULE_14
            next_cr0[CR_EQ] = (sum[31:0] == 32'h00000000);
            next_cr0[CR_SO] = next_xer[XER_SO];
          end
        end
      end
      ST_RDG: begin
        next_st     = ST_IDLE;
        next_rvalid = 1'b1;
        next_rresp  = RESP_OKAY;
        next_rdata  = rdata_a;
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= ST_IDLE;
      instr  <= 32'h00000000;
      current_instr_addr    <= RST_CIA;
      next_instr_addr    <= RST_CIA;
      fixed_point_exception_reg    <= RST_XER;
      cr0    <= RST_CR0;
      bad    <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h00000000;
    end else begin
      st     <= next_st;
      instr  <= next_instr;
      current_instr_addr    <= next_cia;
      next_instr_addr    <= next_nia;
      fixed_point_exception_reg    <= next_xer;
      cr0    <= next_cr0;
      bad    <= next_bad;
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [32:0] chk_sum;  // independent unsigned sum for the carry check
  assign chk_sum = {1'b0, rdata_a} + {1'b0, rdata_b}
                 + {32'h00000000, (op == OP_ADDE) & fixed_point_exception_reg[XER_CA]};

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ADD_SUM: assert property ( // see RULE_01
    (st == ST_EXEC && op == OP_ADD) |-> mem_we && mem_wdata == rdata_a + rdata_b
      && mem_waddr == target_reg_field ##1 $stable(fixed_point_exception_reg[XER_CA])
  ) else $error("plain sum wrong or carry touched");

  AST_CARRY: assert property ( // see RULE_03
    (st == ST_EXEC && (op == OP_ADDC || op == OP_ADDE))
      |=> fixed_point_exception_reg[XER_CA] == $past(chk_sum[32])
  ) else $error("carry flag not set from unsigned sum");

  AST_ADDE_CIN: assert property ( // see RULE_04
    (st == ST_EXEC && op == OP_ADDE)
      |-> mem_wdata == rdata_a + rdata_b + {31'h00000000, fixed_point_exception_reg[XER_CA]}
  ) else $error("extended sum ignores carry in");

  AST_DECODE: assert property ( // see RULE_07
    (instr[OPC_LSB +: 6] == 6'h1f && instr[XO_LSB +: 9] == 9'h00a) |-> op == OP_ADDC
  ) else $error("carrying sum not decoded");

  AST_DECODE_E: assert property ( // see RULE_08
    (instr[OPC_LSB +: 6] == 6'h1f && instr[XO_LSB +: 9] == 9'h08a) |-> op == OP_ADDE
  ) else $error("extended sum not decoded");

  AST_ADDI_ZERO: assert property ( // see RULE_09
    (st == ST_EXEC && op == OP_ADDI && source_a_field == 5'h00)
      |-> mem_wdata == {{16{constant_operand_field[15]}}, constant_operand_field}
  ) else $error("zero-source immediate not loaded as constant");

  AST_ADDI_FLAGS: assert property ( // see RULE_10
    (st == ST_EXEC && op == OP_ADDI) |=> $stable(fixed_point_exception_reg) && $stable(cr0)
  ) else $error("immediate sum altered flags");

  AST_NIA: assert property ( // see RULE_11
    (st == ST_EXEC && op != OP_BAD) |=> next_instr_addr == $past(current_instr_addr) + 32'h00000004 && current_instr_addr == next_instr_addr
  ) else $error("next address is not current plus four");

  AST_OV: assert property ( // see RULE_13
    (st == ST_EXEC && reg_form && ovf_enable_bit)
      |=> fixed_point_exception_reg[XER_OV] == $past(sov) && fixed_point_exception_reg[XER_SO] == ($past(fixed_point_exception_reg[XER_SO]) | $past(sov))
  ) else $error("signed wrap flags not updated");

  AST_CR0: assert property ( // see RULE_14
    (st == ST_EXEC && reg_form && record_bit)
      |=> cr0[CR_EQ] == ($past(sum[31:0]) == 32'h00000000)
        && cr0[CR_LT] == $past(sum[31]) && cr0[CR_SO] == fixed_point_exception_reg[XER_SO]
  ) else $error("condition field zero wrong");

  AST_NO_RC: assert property ( // see RULE_05
    (st == ST_EXEC && reg_form && !record_bit) |=> $stable(cr0)
  ) else $error("condition field changed without record bit");

endmodule

`default_nettype wire

// ==== iad_gpr_mem.sv ====
/*
  General register file: one write port, two read ports, read data
  registered. Assumes the caller never relies on write-then-read in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module iad_gpr_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             aclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  output logic      [WIDTH-1:0] rdata_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_b
);

  logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset as in a real array

  ////////////////////////////////////////////////////////////////////////
  // write and registered read; a read of the word being written sees the old value
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule

`default_nettype wire

// ==== iad_pkg.sv ====
/*
  Shared constants and types for the integer add datapath: register
  offsets, field positions, reset values, operation codes and states.
  Assumes a 32-bit big-endian-numbered instruction word held with bit 0 at the MSB.
*/
`default_nettype none

package iad_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] OFS_INSTR = 8'h00;  // write launches one instruction
  localparam logic [7:0] OFS_CIA   = 8'h04;  // current instruction address
  localparam logic [7:0] OFS_NIA   = 8'h08;  // next instruction address, read only
  localparam logic [7:0] OFS_XER   = 8'h0c;  // fixed point exception register
  localparam logic [7:0] OFS_CR0   = 8'h10;  // condition field zero
  localparam logic [7:0] OFS_STAT  = 8'h14;  // status, read only
  localparam int         GPR_SEL   = 7;      // address bit marking the register window

  // fixed point exception register bits
  localparam int          XER_SO   = 31;  // sticky signed wrap
  localparam int          XER_OV   = 30;  // signed wrap flag
  localparam int          XER_CA   = 29;  // unsigned wrap bit
  localparam logic [31:0] XER_MASK = 32'he0000000;

  // condition field zero bits
  localparam int CR_LT = 3;
  localparam int CR_GT = 2;
  localparam int CR_EQ = 1;
  localparam int CR_SO = 0;

  // status bits
  localparam int STAT_BAD = 0;  // last instruction not recognised

  // instruction field positions, as indices of a [31:0] word
  localparam int OPC_LSB = 26;  // primary opcode, big-endian bits 0-5
  localparam int RT_LSB  = 21;  // target field, bits 6-10
  localparam int RA_LSB  = 16;  // first source, bits 11-15
  localparam int RB_LSB  = 11;  // second source, bits 16-20
  localparam int OE_BIT  = 10;  // overflow enable, bit 21
  localparam int XO_LSB  = 1;   // extended opcode, bits 22-30
  localparam int RC_BIT  = 0;   // record bit, bit 31

  // operation codes
  localparam logic [5:0] OPC_X   = 6'h1f;   // primary code 31
  localparam logic [8:0] XO_ADDC = 9'h00a;  // extended code 10
  localparam logic [8:0] XO_ADDE = 9'h08a;  // extended code 138

  // sequential step and reset values
  localparam logic [31:0] NIA_STEP = 32'h00000004;
  localparam logic [31:0] RST_CIA  = 32'h00000000;
  localparam logic [31:0] RST_XER  = 32'h00000000;
  localparam logic [3:0]  RST_CR0  = 4'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_RDG} iad_state_t;
  typedef enum logic [2:0] {OP_ADD, OP_ADDC, OP_ADDE, OP_ADDI, OP_BAD} iad_op_t;

endpackage

`default_nettype wire

// ==== integer_add_datapath_tb.sv ====
/*
  Self-checking bench: a reference model of the add datapath is compared
  with the design after every instruction. Assumes the register map of iad_pkg.
*/
`timescale 1ns/1ps
`default_nettype none

module integer_add_datapath_tb;
  import iad_pkg::*;
  localparam logic [5:0] P_ADDI = 6'h0e;   // immediate sum primary code
  localparam logic [8:0] P_ADD  = 9'h10a;  // plain sum extended code
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          n_errors, n_tests, cyc;
  logic [31:0] gpr [32];  // model register file
  logic [31:0] fixed_point_exception_reg, current_instr_addr, stat, rv;
  logic [3:0]  cr0;
  logic [1:0]  rs;

  iad_axi_master bus (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  iad_core #(.OPC_ADDI(P_ADDI), .XO_ADD(P_ADD)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // verdict and end of run
  task automatic test_done;
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, far above the fewer than two thousand cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // read a register and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus.rd(a, rv, rs);
    chk(nm, e, rv);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask

  task automatic setg(input logic [4:0] n, input logic [31:0] v);
    bus.wr({1'b1, n, 2'b00}, v, 4'hf, rs);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    gpr[n] = v;
  endtask

  // target register and every special register but the instruction, after one instruction
  task automatic chk_all(input logic [4:0] rt);
    rdc({1'b1, rt, 2'b00}, gpr[rt], "target");
    rdc(OFS_XER, fixed_point_exception_reg, "xer");
    rdc(OFS_CR0, {28'h0, cr0}, "cr0");
    rdc(OFS_NIA, current_instr_addr, "nia");
    rdc(OFS_CIA, current_instr_addr, "cia");
    rdc(OFS_STAT, stat, "stat");
  endtask

  // k: 0 plain, 1 carrying, 2 extended, 3 immediate
  task automatic run(input int k, input logic [4:0] rt, ra, rb, input logic oe, rc, input logic [15:0] im);
    logic [31:0] a, b, ins;
    logic [32:0] s;
    logic        ov;
    a = gpr[ra];
    b = gpr[rb];
    ins = {OPC_X, rt, ra, rb, oe, (k == 0) ? P_ADD : (k == 1) ? XO_ADDC : XO_ADDE, rc};
    if (k == 3) begin
      a = (ra == 5'h0) ? 32'h0 : gpr[ra];
      b = {{16{im[15]}}, im};
      ins = {P_ADDI, rt, ra, im};
    end
    s = {1'b0, a} + {1'b0, b} + ((k == 2) ? {32'h0, fixed_point_exception_reg[XER_CA]} : 33'h0);
    bus.wr(OFS_INSTR, ins, 4'hf, rs);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
    gpr[rt] = s[31:0];
    current_instr_addr = current_instr_addr + 32'h4;
    stat = 32'h0;
    if (k == 1 || k == 2) fixed_point_exception_reg[XER_CA] = s[32];
    if (k < 3 && oe) begin
      ov = (a[31] == b[31]) && (s[31] != a[31]);
      fixed_point_exception_reg[XER_OV] = ov;
      fixed_point_exception_reg[XER_SO] = fixed_point_exception_reg[XER_SO] | ov;
    end
    if (k < 3 && rc) cr0 = {s[31], !s[31] && s[31:0] != 32'h0, s[31:0] == 32'h0, fixed_point_exception_reg[XER_SO]};
    chk_all(rt);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    aresetn = 1'b0;
    {fixed_point_exception_reg, current_instr_addr, stat, cr0} = '0;
    rv = $urandom(32'hcccbf6aa);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0, "reset value");
    for (int i = 0; i < 32; i++) setg(5'(i), $urandom);
    // refused accesses leave state alone
    bus.wr(8'h84, 32'h1234, 4'h3, rs);
    chk("part strobe", {30'h0, RESP_SLVERR}, {30'h0, rs});
    rdc(8'h84, gpr[1], "gpr kept");
    bus.wr(8'h40, 32'h1, 4'hf, rs);
    chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, rs});
    bus.rd(8'h40, rv, rs);
    chk("unmapped rd", 32'h0, rv);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    bus.wr(OFS_XER, 32'hffffffff, 4'hf, rs);
    rdc(OFS_XER, XER_MASK, "xer mask");
    bus.wr(OFS_XER, 32'h0, 4'hf, rs);
    bus.wr(OFS_CIA, 32'h1000, 4'hf, rs);
    current_instr_addr = 32'h1000;
    // carry, overflow and sign boundaries
    setg(1, 32'hffffffff);
    setg(2, 32'h1);
    setg(5, 32'h7fffffff);
    run(1, 3, 1, 2, 1, 1, 0);
    run(0, 7, 1, 1, 0, 1, 0);
    run(2, 4, 2, 2, 1, 1, 0);
    run(0, 6, 5, 2, 1, 1, 0);
    run(3, 8, 0, 0, 1, 1, 16'h8000);
    run(3, 9, 5, 0, 0, 0, 16'h7fff);
    // unrecognised word flags status only
    bus.wr(OFS_INSTR, 32'h0, 4'hf, rs);
    stat = 32'h1;
    chk_all(9);
    repeat (60) begin
      if ($urandom_range(0, 3) == 0) begin
        fixed_point_exception_reg = $urandom & XER_MASK;
        bus.wr(OFS_XER, fixed_point_exception_reg, 4'hf, rs);
      end
      run($urandom_range(0, 3), 5'($urandom), 5'($urandom), 5'($urandom), 1'($urandom), 1'($urandom),
          16'($urandom));
    end
    test_done;
  end
endmodule

`default_nettype wire
